// *** hw/ttc_defines.vh ***
// Purpose: Constants for the triple timer/counter unit (register indices, fields, reset values).
// Assumes: Register byte address is four times the register index.
// Notes: Definitions only; included by bare name.
`ifndef TTC_DEFINES_VH
`define TTC_DEFINES_VH

// ************************************************************
// Register indices (byte address = index * 4)
// ************************************************************
`define TTC_IDX_T01_CTL 10'h088
`define TTC_IDX_T01_MODE 10'h089
`define TTC_IDX_T0_LO 10'h08a
`define TTC_IDX_T0_HI 10'h08b
`define TTC_IDX_T1_LO 10'h08c
`define TTC_IDX_T1_HI 10'h08d
`define TTC_IDX_T2_CTL 10'h0f1
`define TTC_IDX_T2_MODE 10'h0f2
`define TTC_IDX_T2_RCAP_LO 10'h0f3
`define TTC_IDX_T2_RCAP_HI 10'h0f4
`define TTC_IDX_T2_LO 10'h0f5
`define TTC_IDX_T2_HI 10'h0f6
`define TTC_IDX_IRQ_STAT 10'h0f8
`define TTC_IDX_IRQ_MASK 10'h0f9

// ************************************************************
// Reset values
// ************************************************************
`define TTC_RST_BYTE 8'h00
`define TTC_RST_IRQ 3'h0

// ************************************************************
// Timer 0/1 control and mode fields
// ************************************************************
`define TTC_TIMER01_CONTROL_TF1 7
`define TTC_TIMER01_CONTROL_TR1 6
`define TTC_TIMER01_CONTROL_TF0 5
`define TTC_TIMER01_CONTROL_TR0 4
`define TTC_TIMER01_MODE_SELECT_CT1 6
`define TTC_TIMER01_MODE_SELECT_CT0 2
`define TTC_MODE_SPLIT 2'd3

// ************************************************************
// Timer 2 control and mode fields
// ************************************************************
`define TTC_T2C_TF2 7
`define TTC_T2C_TIMER2_EXT_FLAG 6
`define TTC_T2C_U0RX 5
`define TTC_T2C_U0TX 4
`define TTC_T2C_EXEN 3
`define TTC_T2C_TR2 2
`define TTC_T2C_CT2 1
`define TTC_T2C_CAP 0
`define TTC_T2M_TIMER2_UPDOWN_ENABLE 0
`define TTC_T2M_OE 1
`define TTC_T2M_U1RX 2
`define TTC_T2M_U1TX 3

// ************************************************************
// Timing
// ************************************************************
`define TTC_MC_LAST 3'd5
`define TTC_T2_MAX 16'hffff
`define TTC_T2_ZERO 16'h0000

`endif

// *** hw/ttc_timer_unit.v ***
// Purpose: Three 16-bit timer/counters with AHB-Lite register access and one interrupt line.
// Assumes: Single clock; pins synchronous to clk; one machine cycle = six clocks.
// Notes: Byte registers sit in bits 7:0 of each word; upper bits read zero.
//
// Summary of operation
// - Three 16-bit timers, timer or counter each.
// - Timer mode advances once per six clocks, except timer 2 in baud mode.
// - Counter mode counts sampled falling pin edges.
// - Timer 0/1 mode register selects counter and mode per timer.
// - Timers 0/1 readable as low/high bytes.
// - Timer 2 mode decoded from control bits.
// - Timer 2 counts down only in up/down reload, trigger disabled and low.
// - Capture mode: overflow flag, trigger captures count.
// - Reload mode overflow sets flag, reloads count.
// - Reload mode trigger edge reloads, sets external flag.
// - Capture/reload interrupt from either timer 2 flag.
// - Up/down with trigger high: up, toggle flag.
// - Down: underflow at reload value, loads FFFF.
// - Baud mode: reload silently, trigger sets flag.
// - Baud timer counts every clock, not cycle.
// - Clock-out: overflow toggles external flag to pin.
// - Clock-out: trigger sets flag; only it interrupts.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "ttc_defines.vh"

module ttc_timer_unit (
	input wire clk, // Core clock
	input wire resetn, // Asynchronous reset, active low
	input wire hsel, // Slave select
	input wire [31:0] haddr, // Byte address
	input wire [1:0] htrans, // Transfer type
	input wire hwrite, // Write not read
	input wire [2:0] hsize, // Transfer size, word only
	input wire [31:0] hwdata, // Write data
	input wire hready, // Bus ready
	output reg hreadyout, // Slave ready
	output reg [31:0] hrdata, // Read data
	output reg hresp, // Always OKAY
	input wire countPinZero, // Timer 0 count pin
	input wire countPinOne, // Timer 1 count pin
	input wire countPinTwoIn, // Timer 2 count pin, input side
	output reg countPinTwoOut, // Timer 2 clock-out level
	output reg countPinTwoOe, // Timer 2 pin driven
	input wire triggerPin, // Timer 2 trigger pin
	output reg t0Req, // Timer 0 request level
	output reg t1Req, // Timer 1 request level
	output reg t2Req, // Timer 2 request level
	output reg irq // Masked status interrupt
);

	// ************************************************************
	// Register storage
	// ************************************************************
	reg [7:0] timer01_control; // Timer 0/1 control
	reg [7:0] timer01_mode_select; // Timer 0/1 mode select
	reg [7:0] tl0; // Timer 0 low byte
	reg [7:0] th0; // Timer 0 high byte
	reg [7:0] tl1; // Timer 1 low byte
	reg [7:0] th1; // Timer 1 high byte
	reg [7:0] timer2_control; // Timer 2 control
	reg [3:0] timer2_mode_ext; // Timer 2 mode extension
	reg [15:0] rcap; // Timer 2 reload/capture pair
	reg [15:0] cnt2; // Timer 2 count
	reg [2:0] irqStat; // Sticky events
	reg [2:0] irqMask; // Event mask
	reg [2:0] phase; // Machine-cycle phase
	reg [3:0] smp; // Pin samples, one per machine cycle
	reg [3:0] fall; // Falling-edge pulses
	reg dWr; // Write data phase pending
	reg dRd; // Read wait cycle pending
	reg dHit; // Address inside the map
	reg [9:0] dIdx; // Captured register index

	// ************************************************************
	// Machine cycle and pin edges
	// ************************************************************
	wire mcTick = (phase == `TTC_MC_LAST); // Last clock of a machine cycle

	// Phase counter, six clocks per machine cycle
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase <= 3'd0;
		end else if (mcTick) begin
			phase <= 3'd0;
		end else begin
			phase <= phase + 3'd1;
		end
	end

	// Sample pins once per machine cycle, flag high-then-low
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			smp <= 4'h0;
			fall <= 4'h0;
		end else if (mcTick) begin
			smp <= {triggerPin, countPinTwoIn, countPinOne, countPinZero};
			fall <= smp & ~{triggerPin, countPinTwoIn, countPinOne, countPinZero};
		end else begin
			fall <= 4'h0; // One-cycle pulse only
		end
	end

	// ************************************************************
	// Timer 0/1 stepping
	// ************************************************************
	// Returns {overflow low, overflow high, high byte, low byte}
	function [17:0] ttcStep;
		input [1:0] mode;
		input incL;
		input incH;
		input [7:0] th;
		input [7:0] tl;
		reg [13:0] s13;
		reg [16:0] s17;
		reg [8:0] s9;
		reg [8:0] h9;
		begin
			s13 = {1'b0, th, tl[4:0]} + 14'h1;
			s17 = {1'b0, th, tl} + 17'h1;
			s9 = {1'b0, tl} + 9'h1;
			h9 = {1'b0, th} + 9'h1;
			ttcStep = {2'b00, th, tl};
			case (mode)
				2'd0: begin
					// 13-bit: five-bit prescaler under the high byte
					if (incL) begin
						ttcStep = {s13[13], 1'b0, s13[12:5], tl[7:5], s13[4:0]};
					end
				end
				2'd1: begin
					// Full 16-bit counter
					if (incL) begin
						ttcStep = {s17[16], 1'b0, s17[15:0]};
					end
				end
				2'd2: begin
					// 8-bit with reload from the high byte
					if (incL) begin
						ttcStep = {s9[8], 1'b0, th, (s9[8] ? th : s9[7:0])};
					end
				end
				default: begin
					// Split: two independent 8-bit counters
					ttcStep = {incL & s9[8], incH & h9[8], (incH ? h9[7:0] : th),
						(incL ? s9[7:0] : tl)};
				end
			endcase
		end
	endfunction

	wire [1:0] mode0 = timer01_mode_select[1:0]; // Timer 0 mode
	wire [1:0] mode1 = timer01_mode_select[5:4]; // Timer 1 mode
	wire tr0 = timer01_control[`TTC_TIMER01_CONTROL_TR0]; // Timer 0 run
	wire tr1 = timer01_control[`TTC_TIMER01_CONTROL_TR1]; // Timer 1 run
	wire tick0 = timer01_mode_select[`TTC_TIMER01_MODE_SELECT_CT0] ? fall[0] : mcTick;
	wire tick1 = timer01_mode_select[`TTC_TIMER01_MODE_SELECT_CT1] ? fall[1] : mcTick;
	wire split0 = (mode0 == `TTC_MODE_SPLIT); // Timer 0 split
	wire [17:0] step0 = ttcStep(mode0, tr0 & tick0, tr1 & mcTick, th0, tl0);
	wire [17:0] step1 = ttcStep(mode1, tr1 & tick1 & (mode1 != `TTC_MODE_SPLIT), 1'b0,
		th1, tl1);
	wire tf0Set = step0[17]; // Timer 0 overflow
	wire tf1Set = split0 ? step0[16] : step1[17]; // Split high byte borrows flag 1

	// ************************************************************
	// Timer 2 mode decode and stepping
	// ************************************************************
	wire exen = timer2_control[`TTC_T2C_EXEN]; // Trigger enable
	wire timer2_updown_enable = timer2_mode_ext[`TTC_T2M_TIMER2_UPDOWN_ENABLE]; // Up/down enable
	wire baudM = timer2_control[`TTC_T2C_U0RX] | timer2_control[`TTC_T2C_U0TX] | timer2_mode_ext[`TTC_T2M_U1RX] |
		timer2_mode_ext[`TTC_T2M_U1TX];
	wire clkoM = ~timer2_control[`TTC_T2C_CAP] & timer2_mode_ext[`TTC_T2M_OE] & ~timer2_control[`TTC_T2C_CT2];
	wire capM = ~baudM & timer2_control[`TTC_T2C_CAP] & ~timer2_mode_ext[`TTC_T2M_OE];
	wire arM = ~baudM & ~capM & ~clkoM; // Auto-reload otherwise
	wire dcenM = arM & timer2_updown_enable; // Up/down variant
	wire plainM = capM | (arM & ~timer2_updown_enable); // Both flags interrupt
	wire downM = dcenM & ~exen & ~smp[3];
	wire tick2 = timer2_control[`TTC_T2C_CT2] ? fall[2] : (baudM | mcTick);
	wire inc2 = timer2_control[`TTC_T2C_TR2] & tick2; // Timer 2 advances
	wire tf2 = timer2_control[`TTC_T2C_TF2]; // Overflow flag
	wire timer2_ext_flag = timer2_control[`TTC_T2C_TIMER2_EXT_FLAG]; // External flag
	reg [15:0] next_cnt2; // Hardware count update
	reg [15:0] next_rcap; // Hardware capture update
	reg tf2Set; // Overflow flag set
	reg exf2Set; // External flag set
	reg exf2Tog; // External flag toggle

	// Timer 2 counting, reload, capture and flag events
	always @* begin
		next_cnt2 = cnt2;
		next_rcap = rcap;
		tf2Set = 1'b0;
		exf2Set = 1'b0;
		exf2Tog = 1'b0;
		if (inc2) begin
			if (downM) begin
				if (cnt2 == rcap) begin
					next_cnt2 = `TTC_T2_MAX;
					tf2Set = 1'b1;
					exf2Tog = 1'b1;
				end else begin
					next_cnt2 = cnt2 - 16'h1; // 0000 wraps, no underflow
				end
			end else if (cnt2 == `TTC_T2_MAX) begin
				next_cnt2 = capM ? `TTC_T2_ZERO : rcap;
				tf2Set = capM | arM;
				exf2Tog = dcenM | clkoM;
			end else begin
				next_cnt2 = cnt2 + 16'h1;
			end
		end
		if (fall[3]) begin
			if (capM & exen) begin
				next_rcap = cnt2;
				exf2Set = 1'b1;
			end else if (arM & ~timer2_updown_enable & exen) begin
				next_cnt2 = rcap;
				exf2Set = 1'b1;
			end else if (baudM & exen) begin
				exf2Set = 1'b1;
			end else if (clkoM) begin
				exf2Set = 1'b1;
			end
		end
	end

	// Timer 2 request condition per mode
	wire t2ReqC = plainM ? (tf2 | timer2_ext_flag) : (dcenM ? tf2 : timer2_ext_flag);
	wire t2Ev = (plainM & (tf2Set | exf2Set)) | (dcenM & tf2Set) |
		(~arM & ~capM & (exf2Set | (exf2Tog & ~timer2_ext_flag))); // New qualifying flag

	// ************************************************************
	// AHB-Lite slave
	// ************************************************************
	wire addrOk = hsel & hready & htrans[1]; // NONSEQ or SEQ taken
	wire wr = dWr & dHit; // Register write this cycle
	wire [7:0] wdata = hwdata[7:0]; // Byte payload
	reg [7:0] rdVal; // Read multiplexer

	// Read data selection by captured index
	always @* begin
		rdVal = 8'h00;
		case (dIdx)
			`TTC_IDX_T01_CTL: rdVal = timer01_control;
			`TTC_IDX_T01_MODE: rdVal = timer01_mode_select;
			`TTC_IDX_T0_LO: rdVal = tl0;
			`TTC_IDX_T0_HI: rdVal = th0;
			`TTC_IDX_T1_LO: rdVal = tl1;
			`TTC_IDX_T1_HI: rdVal = th1;
			`TTC_IDX_T2_CTL: rdVal = timer2_control;
			`TTC_IDX_T2_MODE: rdVal = {4'h0, timer2_mode_ext};
			`TTC_IDX_T2_RCAP_LO: rdVal = rcap[7:0];
			`TTC_IDX_T2_RCAP_HI: rdVal = rcap[15:8];
			`TTC_IDX_T2_LO: rdVal = cnt2[7:0];
			`TTC_IDX_T2_HI: rdVal = cnt2[15:8];
			`TTC_IDX_IRQ_STAT: rdVal = {5'h00, irqStat};
			`TTC_IDX_IRQ_MASK: rdVal = {5'h00, irqMask};
			default: rdVal = 8'h00; // Unmapped reads zero
		endcase
		if (!dHit) begin
			rdVal = 8'h00;
		end
	end

	// Bus phases: writes need no wait, reads take one wait state
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dWr <= 1'b0;
			dRd <= 1'b0;
			dHit <= 1'b0;
			dIdx <= 10'h000;
			hreadyout <= 1'b1;
			hrdata <= 32'h00000000;
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0; // Always OKAY
			dWr <= addrOk & hwrite;
			dRd <= addrOk & ~hwrite;
			if (addrOk) begin
				dIdx <= haddr[11:2];
				dHit <= (haddr[31:12] == 20'h00000);
			end
			hreadyout <= ~(addrOk & ~hwrite); // Wait state for reads
			if (dRd) begin
				hrdata <= {24'h000000, rdVal}; // Sampled at the wait cycle
			end
		end
	end

	// ************************************************************
	// Register and counter update
	// ************************************************************
	wire wTcon = wr & (dIdx == `TTC_IDX_T01_CTL); // Control write
	wire wT2con = wr & (dIdx == `TTC_IDX_T2_CTL); // Timer 2 control write
	wire [7:0] tconW = wTcon ? wdata : timer01_control; // Software view of control
	wire [7:0] t2conW = wT2con ? wdata : timer2_control; // Software view of timer 2 control
	wire [2:0] irqEv = {t2Ev, tf1Set, tf0Set}; // Status events
	wire [2:0] irqClr = (wr & (dIdx == `TTC_IDX_IRQ_STAT)) ? wdata[2:0] : 3'h0; // Write one clears
	wire [2:0] next_irqStat = (irqStat & ~irqClr) | irqEv; // Set wins over clear

	// Registers, counts and flags; hardware flag set beats software clear
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timer01_control <= `TTC_RST_BYTE;
			timer01_mode_select <= `TTC_RST_BYTE;
			tl0 <= `TTC_RST_BYTE;
			th0 <= `TTC_RST_BYTE;
			tl1 <= `TTC_RST_BYTE;
			th1 <= `TTC_RST_BYTE;
			timer2_control <= `TTC_RST_BYTE;
			timer2_mode_ext <= 4'h0;
			rcap <= {`TTC_RST_BYTE, `TTC_RST_BYTE};
			cnt2 <= {`TTC_RST_BYTE, `TTC_RST_BYTE};
			irqStat <= `TTC_RST_IRQ;
			irqMask <= `TTC_RST_IRQ;
		end else begin
			// Timer 0/1 flags
			timer01_control <= {tconW[7] | tf1Set, tconW[6], tconW[5] | tf0Set, tconW[4:0]};
			if (wr & (dIdx == `TTC_IDX_T01_MODE)) begin
				timer01_mode_select <= wdata;
			end
			// Counts: software write beats hardware step
			tl0 <= (wr & (dIdx == `TTC_IDX_T0_LO)) ? wdata : step0[7:0];
			th0 <= (wr & (dIdx == `TTC_IDX_T0_HI)) ? wdata : step0[15:8];
			tl1 <= (wr & (dIdx == `TTC_IDX_T1_LO)) ? wdata : step1[7:0];
			th1 <= (wr & (dIdx == `TTC_IDX_T1_HI)) ? wdata : step1[15:8];
			// Timer 2 flags
			timer2_control[`TTC_T2C_TF2] <= t2conW[`TTC_T2C_TF2] | tf2Set;
			if (exf2Set) begin
				timer2_control[`TTC_T2C_TIMER2_EXT_FLAG] <= 1'b1;
			end else if (exf2Tog) begin
				timer2_control[`TTC_T2C_TIMER2_EXT_FLAG] <= ~timer2_ext_flag; // Seventeenth bit / clock-out
			end else begin
				timer2_control[`TTC_T2C_TIMER2_EXT_FLAG] <= t2conW[`TTC_T2C_TIMER2_EXT_FLAG];
			end
			timer2_control[5:0] <= t2conW[5:0];
			if (wr & (dIdx == `TTC_IDX_T2_MODE)) begin
				timer2_mode_ext <= wdata[3:0];
			end
			rcap[7:0] <= (wr & (dIdx == `TTC_IDX_T2_RCAP_LO)) ? wdata : next_rcap[7:0];
			rcap[15:8] <= (wr & (dIdx == `TTC_IDX_T2_RCAP_HI)) ? wdata : next_rcap[15:8];
			cnt2[7:0] <= (wr & (dIdx == `TTC_IDX_T2_LO)) ? wdata : next_cnt2[7:0];
			cnt2[15:8] <= (wr & (dIdx == `TTC_IDX_T2_HI)) ? wdata : next_cnt2[15:8];
			// Interrupt status and mask
			irqStat <= next_irqStat;
			if (wr & (dIdx == `TTC_IDX_IRQ_MASK)) begin
				irqMask <= wdata[2:0];
			end
		end
	end

	// ************************************************************
	// Registered outputs
	// ************************************************************
	// Requests, interrupt and clock-out pin from flops
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			t0Req <= 1'b0;
			t1Req <= 1'b0;
			t2Req <= 1'b0;
			irq <= 1'b0;
			countPinTwoOut <= 1'b0;
			countPinTwoOe <= 1'b0;
		end else begin
			t0Req <= timer01_control[`TTC_TIMER01_CONTROL_TF0];
			t1Req <= timer01_control[`TTC_TIMER01_CONTROL_TF1];
			t2Req <= t2ReqC;
			irq <= |(irqStat & irqMask);
			countPinTwoOut <= timer2_ext_flag;
			countPinTwoOe <= clkoM; // Drive only in clock-out mode
		end
	end

endmodule // ttc_timer_unit

// *** tb/ttc_props.sv ***
// Purpose: Port checks for the triple timer/counter unit.
// Assumes: One clock domain; bound to the top module.
// Notes: Sees top-level ports only.
`timescale 1ns/1ps
module ttc_props (
	input wire clk,
	input wire resetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire [31:0] hrdata,
	input wire hresp,
	input wire countPinTwoOut,
	input wire countPinTwoOe,
	input wire triggerPin,
	input wire t2Req,
	input wire irq
);
	// ********
	// Checks
	// ********
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire taken = hsel && hready && htrans[1]; // Transfer accepted
	chk_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait not one cycle");
	chk_write_nowait: assert property (taken && hwrite |=> hreadyout)
		else $error("write stalled");
	chk_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data moved");
	chk_upper_zero: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_unmapped_zero: assert property (taken && !hwrite && haddr[31:12] != 20'h0
		|-> ##2 hrdata == 32'h0)
		else $error("unmapped read not zero");
	chk_resp_okay: assert property (!hresp)
		else $error("error response");
	chk_clkout_req: assert property (countPinTwoOe && $past(countPinTwoOe)
		|-> t2Req == countPinTwoOut)
		else $error("clock-out request not from flag");
	chk_trig_flag: assert property (countPinTwoOe && $fell(triggerPin)
		|-> ##[1:16] countPinTwoOut)
		else $error("trigger did not set flag");
	cover property (taken && !hwrite);
	cover property ($rose(countPinTwoOut));
	cover property ($rose(irq));
endmodule // ttc_props

bind ttc_timer_unit ttc_props u_props (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
	.hresp(hresp), .countPinTwoOut(countPinTwoOut), .countPinTwoOe(countPinTwoOe),
	.triggerPin(triggerPin), .t2Req(t2Req), .irq(irq));

// *** tb/ttc_pin_model.sv ***
// Purpose: External pins seen by the timer unit.
// Assumes: Pins idle high through pull-ups.
// Notes: Each level is held twelve clocks.
`timescale 1ns/1ps
module ttc_pin_model (
	input wire clk,
	input wire countPinTwoOut,
	input wire countPinTwoOe,
	output reg countPinZero,
	output reg countPinOne,
	output reg triggerPin,
	output wire countPinTwoIn
);
	reg pinTwoDrive; // Far-side level on timer 2 pin
	// Shared pin: design level when enabled, else pull-up
	assign countPinTwoIn = countPinTwoOe ? countPinTwoOut : pinTwoDrive;
	// Idle levels
	initial begin
		countPinZero = 1'h1;
		countPinOne = 1'h1;
		triggerPin = 1'h1;
		pinTwoDrive = 1'h1;
	end
	// Set one pin, then hold it
	task level(input integer sel, input reg lvl);
		begin
			case (sel)
				0: countPinZero <= lvl;
				1: countPinOne <= lvl;
				default: triggerPin <= lvl;
			endcase
			repeat (12) @(posedge clk);
		end
	endtask
	// Falling edges, each low then high
	task pulse(input integer sel, input integer n);
		integer i;
		begin
			for (i = 0; i < n; i = i + 1) begin
				level(sel, 1'h0);
				level(sel, 1'h1);
			end
		end
	endtask
endmodule // ttc_pin_model

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the triple timer/counter unit.
// Assumes: Register byte address is index times four.
// Notes: One task per scenario; watchdog cuts hangs.
`timescale 1ns/1ps
`include "ttc_defines.vh"
module tb_top;
	// ********
	// Signals
	// ********
	reg clk = 1'h0; // Core clock
	reg resetn = 1'h0; // Reset, active low
	reg hsel = 1'h0; // Select
	reg [31:0] haddr = 32'h0; // Address
	reg [1:0] htrans = 2'h0; // Transfer type
	reg hwrite = 1'h0; // Direction
	reg [2:0] hsize = 3'h2; // Word size
	reg [31:0] hwdata = 32'h0; // Write data
	wire hreadyout, hresp, irq, t0Req, t1Req, t2Req;
	wire [31:0] hrdata;
	wire countPinZero, countPinOne, countPinTwoIn, countPinTwoOut, countPinTwoOe, triggerPin;
	reg [31:0] rdq; // Last read word
	integer failures = 0; // Mismatches
	integer checksDone = 0; // Comparisons
	integer n; // Cycle count
	integer k; // Loop index
	reg v; // Last pin level
	ttc_timer_unit DUT (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.countPinZero(countPinZero), .countPinOne(countPinOne), .countPinTwoIn(countPinTwoIn),
		.countPinTwoOut(countPinTwoOut), .countPinTwoOe(countPinTwoOe),
		.triggerPin(triggerPin), .t0Req(t0Req), .t1Req(t1Req), .t2Req(t2Req), .irq(irq));
	ttc_pin_model PM (.clk(clk), .countPinTwoOut(countPinTwoOut), .countPinTwoOe(countPinTwoOe),
		.countPinZero(countPinZero), .countPinOne(countPinOne), .triggerPin(triggerPin),
		.countPinTwoIn(countPinTwoIn));
	// Clock, 40 ns period
	initial begin
		forever #20 clk = ~clk;
	end
	// ********
	// Helpers
	// ********
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			checksDone = checksDone + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("BAD t=%0t seen %h want %h", $time, seen, exp);
			end
		end
	endtask
	// One single transfer: address phase, then data phase
	task xfer(input reg w, input [29:0] i, input [7:0] d);
		begin
			@(posedge clk);
			hsel <= 1'h1;
			htrans <= 2'h2;
			haddr <= {i, 2'h0};
			hwrite <= w;
			@(posedge clk);
			while (!hreadyout) @(posedge clk);
			hsel <= 1'h0;
			htrans <= 2'h0;
			hwdata <= {24'h0, d};
			@(posedge clk);
			while (!hreadyout) @(posedge clk);
			rdq = hrdata;
		end
	endtask
	task wr(input [29:0] i, input [7:0] d);
		xfer(1'h1, i, d);
	endtask
	task rc(input [29:0] i, input [7:0] e);
		begin
			xfer(1'h0, i, 8'h0);
			chk(rdq, {24'h0, e});
		end
	endtask
	// ********
	// Scenarios
	// ********
	// Reset value, byte access, unmapped places
	task t_regs;
		begin
			rc(`TTC_IDX_T2_CTL, 8'h00);
			wr(`TTC_IDX_T0_LO, 8'ha5);
			wr(`TTC_IDX_T0_HI, 8'h5a);
			rc(`TTC_IDX_T0_LO, 8'ha5);
			rc(`TTC_IDX_T0_HI, 8'h5a);
			rc(30'h400, 8'h00);
			rc(30'h000, 8'h00);
		end
	endtask
	// Timer 0 16-bit overflow timing, interrupt mask and clear
	task t_t0;
		begin
			wr(`TTC_IDX_T01_MODE, 8'h01);
			wr(`TTC_IDX_T0_LO, 8'hf0);
			wr(`TTC_IDX_T0_HI, 8'hff);
			wr(`TTC_IDX_IRQ_MASK, 8'h01);
			wr(`TTC_IDX_T01_CTL, 8'h10);
			n = 0;
			while (!t0Req) begin
				@(posedge clk);
				n = n + 1;
			end
			chk(n >= 90 && n <= 106, 1);
			rc(`TTC_IDX_T01_CTL, 8'h30);
			repeat (2) @(posedge clk);
			chk(irq, 1);
			wr(`TTC_IDX_IRQ_MASK, 8'h00);
			repeat (2) @(posedge clk);
			chk(irq, 0);
			wr(`TTC_IDX_IRQ_MASK, 8'h01);
			repeat (2) @(posedge clk);
			chk(irq, 1);
			wr(`TTC_IDX_T01_CTL, 8'h00);
			wr(`TTC_IDX_IRQ_STAT, 8'h01);
			repeat (2) @(posedge clk);
			chk({t0Req, irq}, 0);
		end
	endtask
	// Counters on pins: timer 1 16-bit, timer 0 8-bit reload
	task t_cnt;
		begin
			wr(`TTC_IDX_T01_MODE, 8'h56);
			wr(`TTC_IDX_T1_LO, 8'h00);
			wr(`TTC_IDX_T0_LO, 8'hfe);
			wr(`TTC_IDX_T0_HI, 8'hfe);
			wr(`TTC_IDX_T01_CTL, 8'h50);
			PM.pulse(1, 3);
			PM.pulse(0, 3);
			rc(`TTC_IDX_T1_LO, 8'h03);
			rc(`TTC_IDX_T0_LO, 8'hff);
			rc(`TTC_IDX_T01_CTL, 8'h70);
			chk(t1Req, 0);
			wr(`TTC_IDX_T01_CTL, 8'h00);
		end
	endtask
	// Timer 2 reload on trigger edge while held still
	task t_t2rl;
		begin
			wr(`TTC_IDX_T2_RCAP_LO, 8'h34);
			wr(`TTC_IDX_T2_RCAP_HI, 8'h12);
			wr(`TTC_IDX_T2_CTL, 8'h0e);
			PM.pulse(2, 1);
			rc(`TTC_IDX_T2_LO, 8'h34);
			rc(`TTC_IDX_T2_HI, 8'h12);
			rc(`TTC_IDX_T2_CTL, 8'h4e);
			chk(t2Req, 1);
			wr(`TTC_IDX_T2_CTL, 8'h00);
		end
	endtask
	// Down count: wrap is no underflow, match is
	task t_t2dn;
		begin
			PM.level(2, 1'h0);
			wr(`TTC_IDX_T2_MODE, 8'h01);
			wr(`TTC_IDX_T2_RCAP_LO, 8'h00);
			wr(`TTC_IDX_T2_RCAP_HI, 8'h80);
			wr(`TTC_IDX_T2_LO, 8'h01);
			wr(`TTC_IDX_T2_HI, 8'h00);
			wr(`TTC_IDX_T2_CTL, 8'h04);
			repeat (30) @(posedge clk);
			rc(`TTC_IDX_T2_HI, 8'hff);
			rc(`TTC_IDX_T2_CTL, 8'h04);
			wr(`TTC_IDX_T2_CTL, 8'h00);
			wr(`TTC_IDX_T2_HI, 8'h80);
			wr(`TTC_IDX_T2_LO, 8'h02);
			wr(`TTC_IDX_T2_CTL, 8'h04);
			repeat (30) @(posedge clk);
			rc(`TTC_IDX_T2_CTL, 8'hc4);
			chk(t2Req, 1);
			wr(`TTC_IDX_T2_CTL, 8'h00);
			wr(`TTC_IDX_T2_MODE, 8'h00);
			PM.level(2, 1'h1);
		end
	endtask
	// Clock output alone, then with baud generation
	task t_t2clk;
		begin
			for (k = 0; k < 2; k = k + 1) begin
				wr(`TTC_IDX_T2_MODE, 8'h02);
				wr(`TTC_IDX_T2_RCAP_LO, 8'hf0);
				wr(`TTC_IDX_T2_RCAP_HI, 8'hff);
				wr(`TTC_IDX_T2_LO, 8'hf0);
				wr(`TTC_IDX_T2_HI, 8'hff);
				wr(`TTC_IDX_T2_CTL, k ? 8'h24 : 8'h04);
				chk(countPinTwoOe, 1);
				v = countPinTwoOut;
				while (countPinTwoOut === v) @(posedge clk);
				n = 0;
				v = countPinTwoOut;
				while (countPinTwoOut === v) begin
					@(posedge clk);
					n = n + 1;
				end
				chk(n, k ? 16 : 96);
				xfer(1'h0, `TTC_IDX_T2_CTL, 8'h0);
				chk(rdq[7], 0);
				wr(`TTC_IDX_T2_CTL, 8'h00);
				if (k == 0) begin
					// Stopped, so only the trigger edge can raise the flag
					PM.pulse(2, 1);
					rc(`TTC_IDX_T2_CTL, 8'h40);
					chk(t2Req, 1);
					wr(`TTC_IDX_T2_CTL, 8'h00);
				end
				wr(`TTC_IDX_T2_MODE, 8'h00);
			end
		end
	endtask
	// ********
	// Sequence and verdict
	// ********
	task results;
		begin
			$display("failures %0d checks %0d", failures, checksDone);
			if (failures == 0 && checksDone > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// Main sequence after reset
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1'h1;
		t_regs;
		t_t0;
		t_cnt;
		t_t2rl;
		t_t2dn;
		t_t2clk;
		results;
	end
	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		failures = failures + 1;
		$display("BAD t=%0t watchdog expired", $time);
		results;
	end
endmodule // tb_top
